// ---- hdl/sac_pkg.sv ----
/*
  Shared constants and types for the serial converter port: word layout,
  edge numbers of the conversion frame, wake intervals and host timing.
  Assumes a 40 MHz system clock on both ends.
*/
package sac_pkg;
  // Word layout
  localparam int         SAC_RES_BITS    = 12;
  localparam int         SAC_LEAD_ZEROS  = 3;
  localparam int         SAC_WORD_BITS   = SAC_RES_BITS + SAC_LEAD_ZEROS;
  // Rising serial clock edge numbers within a frame
  localparam logic [4:0] SAC_CONV_EDGES  = 5'h10;
  localparam logic [4:0] SAC_TRACK_EDGE  = 5'h0e;
  localparam logic [4:0] SAC_PD_FIRST    = 5'h03;
  localparam logic [4:0] SAC_EXIT_EDGES  = 5'h0e;
  localparam logic [4:0] SAC_MSB_EDGE    = 5'h04;
  localparam logic [4:0] SAC_LSB_EDGE    = 5'h0f;
  // Host raises convert_start_n after these edges
  localparam logic [4:0] SAC_CONT_RAISE  = 5'h0f;
  localparam logic [4:0] SAC_PD_RAISE    = 5'h08;
  localparam logic [4:0] SAC_WAKE_RAISE  = 5'h10;
  // Wake and acquisition intervals
  localparam logic [4:0] SAC_RESTART_SCLK = 5'h10;
  localparam int         SAC_ACQ_SCLK     = 3;
  localparam int         SAC_PWRUP_MS     = 2;
  localparam int         SAC_SYS_CLK_HZ   = 40_000_000;
  localparam int         SAC_PWRUP_CYCLES = SAC_PWRUP_MS * (SAC_SYS_CLK_HZ / 1000);
  // Host serial clock half period in system cycles
  localparam int         SAC_SCLK_HALF    = 4;

  typedef enum logic [2:0] {
    SAC_PWR_NORMAL  = 3'b001,
    SAC_PWR_PARTIAL = 3'b010,
    SAC_PWR_FULL    = 3'b100
  } sac_pwr_e;

  typedef enum logic [2:0] {
    SAC_CMD_CONVERT = 3'b001,
    SAC_CMD_SLEEP   = 3'b010,
    SAC_CMD_WAKE    = 3'b100
  } sac_cmd_e;

  function automatic sac_pwr_e sac_deeper(input sac_pwr_e m);
    return (m == SAC_PWR_NORMAL) ? SAC_PWR_PARTIAL : SAC_PWR_FULL;
  endfunction : sac_deeper
endpackage : sac_pkg

// ---- hdl/sac_link_if.sv ----
/*
  Three-wire link between host and converter ends.
  Assumes the host drives sclk and convert_start_n; dout_line is resolved here.
*/
`timescale 1ns/100ps
`default_nettype none
interface sac_link_if;
  logic sclk;
  logic convert_start_n;
  logic dout_d;
  logic dout_oe;
  wire  dout_line;

  // No pull on the line: a released line shows the inverse of the last bit
  assign dout_line = dout_oe ? dout_d : ~dout_d;

  modport dev (input sclk, input convert_start_n, output dout_d, output dout_oe);
  modport hst (output sclk, output convert_start_n, input dout_line);
endinterface : sac_link_if
`default_nettype wire

// ---- hdl/sac_sync_edge.sv ----
/*
  Two-flop synchroniser with edge detect on the synchronised level.
  Assumes async_i is from outside the sys_clk_i domain.
*/
`timescale 1ns/100ps
`default_nettype none
module sac_sync_edge #(
  // Idle level of the pin, so reset gives no false edge
  parameter logic RST_LEVEL = 1'b0
) (
  // Clock and control
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  // Signal
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta;
  logic sync;
  logic last;
  logic next_meta;
  logic next_sync;
  logic next_last;

  always_comb begin
    next_meta = async_i;
    next_sync = meta;
    next_last = sync;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta <= RST_LEVEL;
      sync <= RST_LEVEL;
      last <= RST_LEVEL;
    end else if (ce_i) begin
      meta <= next_meta;
      sync <= next_sync;
      last <= next_last;
    end
  end

  assign level_o = sync;
  assign rise_o  = sync & ~last;
  assign fall_o  = ~sync & last;
endmodule : sac_sync_edge
`default_nettype wire

// ---- hdl/sac_adc_end.sv ----
/*
  Converter end of the three-wire port: conversion sequencing, serial
  read-out, power-down entry and exit, wake timing.
  Assumes sclk and convert_start_n come from the host on its own timing.
*/
// Functional notes
// - A conversion spans sixteen serial clock periods.
// - Track from 14th rising edge until start.
// - Idle between conversions means tracking.
// - Host leaves three clocks acquisition between frames.
// - Data output updates on each rising edge.
// - Host holds convert-start high before requesting.
// - Convert-start falling edge samples and starts.
// - Serial clock paces conversion and shifting.
// - Partial wake needs sixteen clocks restart.
// - Full wake needs two milliseconds power-up.
// - Three zeros, then twelve bits MSB first.
// - Host raises start between edges 14-16.
// - Late low start releases output next edge.
// - Early raise powers down; long low exits.
`timescale 1ns/100ps
`default_nettype none
module sac_adc_end
  import sac_pkg::*;
#(
  parameter int PWRUP_CYCLES = sac_pkg::SAC_PWRUP_CYCLES
) (
  // Clock and control
  input  wire logic                          sys_clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          ce_i,
  // Link
  sac_link_if.dev                            link,
  // Converted value presented by the analog side
  input  wire logic [sac_pkg::SAC_RES_BITS-1:0] sample_i,
  // Status and result
  output logic [sac_pkg::SAC_RES_BITS-1:0]   result_o,
  output logic                               result_valid_o,
  output logic                               tracking_o,
  output logic                               busy_o,
  output logic                               ready_o,
  output sac_pkg::sac_pwr_e                  pwr_mode_o
);
  typedef enum logic [3:0] {
    SD_TRACK   = 4'b0001,
    SD_CONV    = 4'b0010,
    SD_DONE    = 4'b0100,
    SD_RELEASE = 4'b1000
  } sac_dev_state_e;

  logic                     sclk_lvl;
  logic                     sclk_rise;
  logic                     sclk_fall;
  logic                     cs_lvl;
  logic                     cs_rise;
  logic                     cs_fall;
  logic                     exit_req;

  sac_dev_state_e           state;
  sac_dev_state_e           next_state;
  logic [4:0]               cnt;
  logic [4:0]               next_cnt;
  logic [SAC_WORD_BITS-1:0] shreg;
  logic [SAC_WORD_BITS-1:0] next_shreg;
  logic [SAC_RES_BITS-1:0]  word;
  logic [SAC_RES_BITS-1:0]  next_word;
  logic                     dout_d;
  logic                     next_dout_d;
  logic                     dout_oe;
  logic                     next_dout_oe;
  logic                     calibrated;
  logic                     next_calibrated;
  logic [4:0]               restart_cnt;
  logic [4:0]               next_restart;
  logic [31:0]              pwrup_cnt;
  logic [31:0]              next_pwrup;
  logic [SAC_RES_BITS-1:0]  next_result;
  logic                     next_result_valid;
  logic                     next_tracking;
  logic                     next_busy;
  logic                     next_ready;
  sac_pwr_e                 next_mode;

  sac_sync_edge u_sclk_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .async_i   (link.sclk),
    .level_o   (sclk_lvl),
    .rise_o    (sclk_rise),
    .fall_o    (sclk_fall)
  );

  sac_sync_edge #(.RST_LEVEL(1'b1)) u_cs_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .async_i   (link.convert_start_n),
    .level_o   (cs_lvl),
    .rise_o    (cs_rise),
    .fall_o    (cs_fall)
  );

  always_comb begin
    next_state        = state;
    next_cnt          = cnt;
    next_shreg        = shreg;
    next_word         = word;
    next_dout_d       = dout_d;
    next_dout_oe      = dout_oe;
    next_calibrated   = calibrated;
    next_restart      = restart_cnt;
    next_pwrup        = pwrup_cnt;
    next_result       = result_o;
    next_result_valid = 1'b0;
    next_tracking     = tracking_o;
    next_busy         = busy_o;
    next_mode         = pwr_mode_o;
    // Wake timers run down on their own clocks
    if (sclk_rise && restart_cnt != 5'h00) begin
      next_restart = restart_cnt - 5'h01;
    end
    if (pwrup_cnt != 32'h0) begin
      next_pwrup = pwrup_cnt - 32'h1;
    end
    exit_req = cs_rise && (pwr_mode_o != SAC_PWR_NORMAL) && (cnt >= SAC_EXIT_EDGES) && (state != SD_TRACK);
    unique case (state)
      SD_TRACK: begin
        if (cs_fall) begin
          next_state    = SD_CONV;
          next_cnt      = 5'h00;
          next_word     = sample_i;
          next_shreg    = {{SAC_LEAD_ZEROS{1'b0}}, sample_i};
          next_dout_oe  = 1'b1;
          next_dout_d   = 1'b0;
          next_tracking = 1'b0;
          next_busy     = 1'b1;
        end
      end
      SD_CONV: begin
        if (cs_rise && cnt >= SAC_PD_FIRST && cnt < SAC_TRACK_EDGE) begin
          // Early raise aborts the frame and steps one level down, staying at full once there
          next_mode     = sac_deeper(pwr_mode_o);
          next_state    = SD_TRACK;
          next_dout_oe  = 1'b0;
          next_tracking = 1'b1;
          next_busy     = 1'b0;
        end else if (sclk_rise) begin
          next_cnt    = cnt + 5'h01;
          next_dout_d = shreg[SAC_WORD_BITS-1];
          next_shreg  = {shreg[SAC_WORD_BITS-2:0], 1'b0};
          if (next_cnt == SAC_TRACK_EDGE) begin
            next_tracking = 1'b1;
          end
          if (next_cnt == SAC_CONV_EDGES) begin
            next_busy       = 1'b0;
            next_calibrated = 1'b1;
            next_result     = word;
            next_result_valid = calibrated && (pwr_mode_o == SAC_PWR_NORMAL) &&
                                (restart_cnt == 5'h00) && (pwrup_cnt == 32'h0);
            next_state      = cs_lvl ? SD_TRACK : SD_DONE;
          end
        end
      end
      SD_DONE: begin
        if (cs_rise) begin
          next_state = SD_TRACK;
        end else if (sclk_fall) begin
          next_state = SD_RELEASE;
        end
      end
      SD_RELEASE: begin
        if (cs_rise || sclk_rise) begin
          next_dout_oe = 1'b0;
          next_state   = SD_TRACK;
        end
      end
    endcase
    if (exit_req) begin
      next_mode = SAC_PWR_NORMAL;
      if (pwr_mode_o == SAC_PWR_PARTIAL) begin
        next_restart = SAC_RESTART_SCLK;
      end else begin
        next_pwrup = 32'(PWRUP_CYCLES);
      end
    end
    next_ready = next_calibrated && (next_mode == SAC_PWR_NORMAL) &&
                 (next_restart == 5'h00) && (next_pwrup == 32'h0);
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state          <= SD_TRACK;
      cnt            <= 5'h00;
      shreg          <= '0;
      word           <= '0;
      dout_d         <= 1'b0;
      dout_oe        <= 1'b0;
      calibrated     <= 1'b0;
      restart_cnt    <= 5'h00;
      pwrup_cnt      <= 32'h0;
      result_o       <= '0;
      result_valid_o <= 1'b0;
      tracking_o     <= 1'b1;
      busy_o         <= 1'b0;
      ready_o        <= 1'b0;
      pwr_mode_o     <= SAC_PWR_NORMAL;
    end else if (ce_i) begin
      state          <= next_state;
      cnt            <= next_cnt;
      shreg          <= next_shreg;
      word           <= next_word;
      dout_d         <= next_dout_d;
      dout_oe        <= next_dout_oe;
      calibrated     <= next_calibrated;
      restart_cnt    <= next_restart;
      pwrup_cnt      <= next_pwrup;
      result_o       <= next_result;
      result_valid_o <= next_result_valid;
      tracking_o     <= next_tracking;
      busy_o         <= next_busy;
      ready_o        <= next_ready;
      pwr_mode_o     <= next_mode;
    end
  end

  assign link.dout_d  = dout_d;
  assign link.dout_oe = dout_oe;
endmodule : sac_adc_end
`default_nettype wire

// ---- hdl/sac_host_end.sv ----
/*
  Host end of the three-wire port: makes the serial clock by division,
  frames convert_start_n for convert, sleep and wake commands, reads the word.
  Assumes commands arrive from logic on sys_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module sac_host_end
  import sac_pkg::*;
#(
  parameter int PWRUP_CYCLES = sac_pkg::SAC_PWRUP_CYCLES,
  parameter int SCLK_HALF    = sac_pkg::SAC_SCLK_HALF
) (
  // Clock and control
  input  wire logic                            sys_clk_i,
  input  wire logic                            sys_rst_i,
  input  wire logic                            ce_i,
  // Link
  sac_link_if.hst                              link,
  // Command
  input  wire logic                            cmd_valid_i,
  input  wire sac_pkg::sac_cmd_e               cmd_i,
  output logic                                 cmd_ready_o,
  // Result
  output logic [sac_pkg::SAC_RES_BITS-1:0]     data_o,
  output logic                                 data_valid_o
);
  typedef enum logic [4:0] {
    SH_IDLE = 5'b00001,
    SH_LEAD = 5'b00010,
    SH_HIGH = 5'b00100,
    SH_LOW  = 5'b01000,
    SH_WAIT = 5'b10000
  } sac_host_state_e;

  localparam int PERIOD = 2 * SCLK_HALF;

  logic                    dout_lvl;
  sac_host_state_e         state;
  sac_host_state_e         next_state;
  sac_cmd_e                cmd;
  sac_cmd_e                next_cmd;
  sac_pwr_e                mode;
  sac_pwr_e                next_mode;
  logic                    sclk_q;
  logic                    next_sclk;
  logic                    cs_n_q;
  logic                    next_cs_n;
  logic [15:0]             div_cnt;
  logic [15:0]             next_div;
  logic [4:0]              edge_cnt;
  logic [4:0]              next_edge;
  logic [31:0]             wait_cnt;
  logic [31:0]             next_wait;
  logic [SAC_RES_BITS-1:0] shreg;
  logic [SAC_RES_BITS-1:0] next_shreg;
  logic [SAC_RES_BITS-1:0] next_data;
  logic                    next_data_valid;
  logic                    next_cmd_ready;
  logic [4:0]              raise_edge;
  logic [4:0]              last_edge;
  logic                    half_done;

  sac_sync_edge #(.RST_LEVEL(1'b1)) u_dout_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .async_i   (link.dout_line),
    .level_o   (dout_lvl),
    .rise_o    (),
    .fall_o    ()
  );

  always_comb begin
    next_state      = state;
    next_cmd        = cmd;
    next_mode       = mode;
    next_sclk       = sclk_q;
    next_cs_n       = cs_n_q;
    next_div        = div_cnt + 16'h1;
    next_edge       = edge_cnt;
    next_wait       = wait_cnt;
    next_shreg      = shreg;
    next_data       = data_o;
    next_data_valid = 1'b0;
    half_done       = (div_cnt == 16'(SCLK_HALF - 1));
    raise_edge      = (cmd == SAC_CMD_CONVERT) ? SAC_CONT_RAISE :
                      (cmd == SAC_CMD_SLEEP) ? SAC_PD_RAISE : SAC_WAKE_RAISE;
    last_edge       = (cmd == SAC_CMD_SLEEP) ? SAC_PD_RAISE : SAC_CONV_EDGES;
    unique case (state)
      SH_IDLE: begin
        next_div = 16'h0;
        if (cmd_valid_i) begin
          next_cmd   = cmd_i;
          next_cs_n  = 1'b0;
          next_edge  = 5'h00;
          next_state = SH_LEAD;
        end
      end
      SH_LEAD: begin
        if (half_done) begin
          next_div   = 16'h0;
          next_sclk  = 1'b1;
          next_edge  = edge_cnt + 5'h01;
          next_state = SH_HIGH;
        end
      end
      SH_HIGH: begin
        if (half_done) begin
          next_div   = 16'h0;
          next_sclk  = 1'b0;
          next_state = SH_LOW;
        end
      end
      SH_LOW: begin
        if (half_done) begin
          next_div = 16'h0;
          // Sample late in the low phase, after both synchroniser delays
          if (edge_cnt >= SAC_MSB_EDGE && edge_cnt <= SAC_LSB_EDGE) begin
            next_shreg = {shreg[SAC_RES_BITS-2:0], dout_lvl};
          end
          if (edge_cnt == raise_edge) begin
            next_cs_n = 1'b1;
          end
          if (edge_cnt == last_edge) begin
            next_state = SH_WAIT;
            unique case (cmd)
              SAC_CMD_CONVERT: begin
                next_data       = next_shreg;
                next_data_valid = 1'b1;
                next_wait       = 32'(SAC_ACQ_SCLK * PERIOD);
              end
              SAC_CMD_SLEEP: begin
                next_mode = sac_deeper(mode);
                next_wait = 32'h1;
              end
              SAC_CMD_WAKE: begin
                next_mode = SAC_PWR_NORMAL;
                next_wait = (mode == SAC_PWR_FULL) ? 32'(PWRUP_CYCLES) :
                            (mode == SAC_PWR_PARTIAL) ? 32'(SAC_RESTART_SCLK) * 32'(PERIOD) : 32'h1;
              end
              default: next_wait = 32'h1;
            endcase
          end else begin
            next_sclk  = 1'b1;
            next_edge  = edge_cnt + 5'h01;
            next_state = SH_HIGH;
          end
        end
      end
      SH_WAIT: begin
        next_div = 16'h0;
        if (wait_cnt <= 32'h1) begin
          next_state = SH_IDLE;
        end
        next_wait = wait_cnt - 32'h1;
      end
    endcase
    next_cmd_ready = (next_state == SH_IDLE);
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state        <= SH_IDLE;
      cmd          <= SAC_CMD_CONVERT;
      mode         <= SAC_PWR_NORMAL;
      sclk_q       <= 1'b0;
      cs_n_q       <= 1'b1;
      div_cnt      <= 16'h0;
      edge_cnt     <= 5'h00;
      wait_cnt     <= 32'h0;
      shreg        <= '0;
      data_o       <= '0;
      data_valid_o <= 1'b0;
      cmd_ready_o  <= 1'b1;
    end else if (ce_i) begin
      state        <= next_state;
      cmd          <= next_cmd;
      mode         <= next_mode;
      sclk_q       <= next_sclk;
      cs_n_q       <= next_cs_n;
      div_cnt      <= next_div;
      edge_cnt     <= next_edge;
      wait_cnt     <= next_wait;
      shreg        <= next_shreg;
      data_o       <= next_data;
      data_valid_o <= next_data_valid;
      cmd_ready_o  <= next_cmd_ready;
    end
  end

  assign link.sclk            = sclk_q;
  assign link.convert_start_n = cs_n_q;
endmodule : sac_host_end
`default_nettype wire

// ---- tb/sac_link_asserts.sv ----
/*
  Concurrent checks on the three-wire link between host and converter ends.
  Assumes it is instantiated beside the link, on the 40 MHz system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sac_link_asserts
  import sac_pkg::*;
#(
  parameter int SCLK_HALF = 4
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk,
  input wire logic convert_start_n,
  input wire logic dout_d,
  input wire logic dout_oe,
  input wire logic dout_line
);
  localparam int GAP_MIN = (SAC_ACQ_SCLK + 1) * 2 * SCLK_HALF;
  logic       sclk_q, cs_q, asleep;
  logic       next_sclk_q, next_cs_q, next_asleep;
  logic [4:0] cnt, next_cnt;
  logic [5:0] since, next_since;

  // Rises in frame, cycles since last rise, low-power belief
  always_comb begin
    next_sclk_q = sclk;
    next_cs_q   = convert_start_n;
    next_cnt    = (cs_q && !convert_start_n) ? 5'h00 : cnt + {4'h0, (sclk && !sclk_q && cnt != 5'h1f)};
    next_since  = (sclk && !sclk_q) ? 6'h00 : since + {5'h00, since != 6'h3f};
    next_asleep = asleep;
    if (convert_start_n && !cs_q) begin
      if (cnt >= SAC_PD_FIRST && cnt < SAC_TRACK_EDGE) begin
        next_asleep = 1'b1;
      end else if (cnt >= SAC_EXIT_EDGES) begin
        next_asleep = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      asleep <= 1'b0;
      cnt    <= 5'h00;
      since  <= 6'h3f;
    end else begin
      sclk_q <= next_sclk_q;
      cs_q   <= next_cs_q;
      asleep <= next_asleep;
      cnt    <= next_cnt;
      since  <= next_since;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_reset_quiet: assert property ($fell(sys_rst_i) |-> !dout_oe)
    else $error("data output driven right after reset");
  chk_start_drives: assert property ($fell(convert_start_n) && !asleep |-> ##[1:6] (dout_oe && !dout_d))
    else $error("start fall did not drive the data output low");
  chk_abort_release: assert property ($rose(convert_start_n) && cnt >= 5'h03 && cnt < 5'h0e |-> ##[1:6] !dout_oe)
    else $error("early raise did not release the data output");
  chk_cont_active: assert property ($rose(convert_start_n) && cnt >= 5'h0e && cnt <= 5'h10 && !asleep
                                    |-> ##1 dout_oe [*8])
    else $error("data output released after continuous raise");
  chk_lead_zeros: assert property ($rose(sclk) && cnt >= 5'h01 && cnt <= 5'h03 && dout_oe |-> !dout_line)
    else $error("leading bit not zero");
  chk_tail_zero: assert property ($fell(convert_start_n) && cnt == SAC_CONV_EDGES && dout_oe |-> !dout_line)
    else $error("bit after sixteenth rise not zero");
  chk_update_rise: assert property (dout_oe && $past(dout_oe) && $changed(dout_d) |-> since <= 6'h06)
    else $error("data bit changed away from a clock rise");
  chk_acq_gap: assert property ($fell(convert_start_n) && cnt == SAC_CONV_EDGES |-> since >= GAP_MIN)
    else $error("acquisition gap too short");

  cover property ($fell(convert_start_n) && !asleep);
  cover property ($rose(convert_start_n) && cnt == SAC_PD_RAISE);
  cover property ($rose(convert_start_n) && cnt == SAC_WAKE_RAISE && asleep);
endmodule : sac_link_asserts
`default_nettype wire

// ---- tb/serial_adc_conversion_port_tb_top.sv ----
/*
  Bench for the converter port: host and converter ends on one link, and a
  second converter end driven directly by the bench on a second link.
  Assumes the package, link and design modules under hdl/ are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_adc_conversion_port_tb_top;
  import sac_pkg::*;
  localparam int PW    = 40;
  localparam int LIMIT = 40000;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        ce        = 1'b1;
  logic        cmd_valid = 1'b0;
  sac_cmd_e    cmd       = SAC_CMD_CONVERT;
  logic [11:0] sample    = 12'h000;
  logic [11:0] sample2   = 12'h000;
  logic [11:0] vals [4]  = '{12'h000, 12'hfff, 12'ha5c, 12'h801};
  logic [11:0] data, result;
  logic        data_valid, cmd_ready, res_valid, tracking, busy, ready, trk2;
  sac_pwr_e    pwr;
  int          err_count = 0;
  int          compares  = 0;
  int          cycles    = 0;

  sac_link_if link ();
  sac_link_if link2 ();

  sac_host_end #(.PWRUP_CYCLES(PW), .SCLK_HALF(SAC_SCLK_HALF)) sac_host_end_inst (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .link(link), .cmd_valid_i(cmd_valid),
    .cmd_i(cmd), .cmd_ready_o(cmd_ready), .data_o(data), .data_valid_o(data_valid));
  sac_adc_end #(.PWRUP_CYCLES(PW)) sac_adc_end_inst (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .link(link), .sample_i(sample),
    .result_o(result), .result_valid_o(res_valid), .tracking_o(tracking), .busy_o(busy),
    .ready_o(ready), .pwr_mode_o(pwr));
  sac_adc_end #(.PWRUP_CYCLES(PW)) sac_adc_end_inst2 (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .link(link2), .sample_i(sample2),
    .result_o(), .result_valid_o(), .tracking_o(trk2), .busy_o(), .ready_o(), .pwr_mode_o());
  sac_link_asserts #(.SCLK_HALF(SAC_SCLK_HALF)) sac_link_asserts_inst (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sclk(link.sclk), .convert_start_n(link.convert_start_n),
    .dout_d(link.dout_d), .dout_oe(link.dout_oe), .dout_line(link.dout_line));

  always #12.5 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count = err_count + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : tick

  task automatic wait_ready();
    int n;
    n = 0;
    tick(2);
    while (cmd_ready !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
  endtask : wait_ready

  task automatic issue(input sac_cmd_e c);
    wait_ready();
    cmd       <= c;
    cmd_valid <= 1'b1;
    tick(1);
    cmd_valid <= 1'b0;
  endtask : issue

  // One conversion through the host; cal marks the first frame after reset
  task automatic convert(input logic [11:0] v, input bit cal, input bit want_rv);
    int n, nd, post, both, rv;
    n = 0;
    nd = 0;
    post = 0;
    both = 0;
    rv = 0;
    sample <= v;
    issue(SAC_CMD_CONVERT);
    while (post < 8 && n < 400) begin
      tick(1);
      n++;
      if (post > 0 || data_valid === 1'b1) post++;
      if (data_valid === 1'b1) nd = n;
      if (busy === 1'b1 && tracking === 1'b1) both++;
      if (res_valid === 1'b1) rv++;
    end
    check(nd >= 132 && nd <= 136, 1);
    check(both, 16);
    check(tracking, 1);
    check(link.dout_oe, 1);
    if (cal) begin
      check(ready, 1);
    end else begin
      check(data, v);
      check(result, v);
      check(rv, want_rv);
    end
  endtask : convert

  task automatic power();
    int n, m;
    n = 0;
    m = 0;
    issue(SAC_CMD_SLEEP);
    wait_ready();
    tick(6);
    check(pwr, SAC_PWR_PARTIAL);
    check(link.dout_oe, 0);
    issue(SAC_CMD_WAKE);
    wait_ready();
    check(pwr, SAC_PWR_NORMAL);
    convert(12'h3c7, 0, 0);
    issue(SAC_CMD_SLEEP);
    issue(SAC_CMD_SLEEP);
    wait_ready();
    tick(6);
    check(pwr, SAC_PWR_FULL);
    issue(SAC_CMD_WAKE);
    while (ready !== 1'b1 && m < 5000) begin
      tick(1);
      m++;
      if (pwr === SAC_PWR_NORMAL) n++;
    end
    check(n >= PW - 2 && n <= PW + 3, 1);
    convert(12'h5a3, 0, 1);
  endtask : power

  // Clock enable low freezes both ends mid-frame
  task automatic freeze(input logic [11:0] v);
    logic sclk_seen;
    sample <= v;
    issue(SAC_CMD_CONVERT);
    tick(40);
    ce <= 1'b0;
    tick(2);
    sclk_seen = link.sclk;
    tick(20);
    check(link.sclk, sclk_seen);
    check(busy, 1);
    ce <= 1'b1;
    wait_ready();
    check(data, v);
    check(result, v);
  endtask : freeze

  // Bench-driven frame that keeps start low past the sixteenth fall
  task automatic far_frame(input logic [11:0] v, input bit chk);
    logic [15:0] word;
    word = 16'h0000;
    sample2 <= v;
    link2.convert_start_n <= 1'b0;
    tick(6);
    for (int k = 0; k < 16; k++) begin
      link2.sclk <= 1'b1;
      tick(4);
      link2.sclk <= 1'b0;
      tick(4);
      word = {word[14:0], link2.dout_line};
    end
    link2.sclk <= 1'b1;
    tick(8);
    if (chk) begin
      check(word, {3'h0, v, 1'b0});
      check(link2.dout_oe, 0);
    end
    link2.sclk <= 1'b0;
    link2.convert_start_n <= 1'b1;
    tick(40);
    check(trk2, 1);
  endtask : far_frame

  initial begin
    link2.sclk = 1'b0;
    link2.convert_start_n = 1'b1;
    tick(10);
    sys_rst_i <= 1'b0;
    tick(2);
    check(tracking, 1);
    check(busy, 0);
    check(pwr, SAC_PWR_NORMAL);
    check(link.dout_oe, 0);
    check(link.convert_start_n, 1);
    convert(12'h000, 1, 0);
    foreach (vals[i]) convert(vals[i], 0, 1);
    freeze(12'h6b2);
    power();
    far_frame(12'h000, 0);
    far_frame(12'h9c3, 1);
    end_of_test();
  end
endmodule : serial_adc_conversion_port_tb_top
`default_nettype wire
